// file: logic/mer_responder.sv
// request checker, parameter store and response framer of the serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "mer_regs.svh"
module mer_responder (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic req_valid_i,
	input wire mer_pkg::mer_byte_type req_slave_i,
	input wire mer_pkg::mer_byte_type req_func_i,
	input wire logic [15:0] req_reg_i,
	input wire logic [15:0] req_data_i,
	input wire logic req_len_ok_i,
	input wire logic req_crc_ok_i,
	input wire logic drive_fault_i,
	input wire logic drive_running_i,
	input wire logic [15:0] user_password_setting_i,
	output logic req_ready_o,
	output mer_pkg::mer_byte_type tx_byte_o,
	output logic tx_valid_o,
	output logic tx_last_o,
	output logic tx_exception_o,
	output logic unlocked_o,
	output logic [15:0] run_command_source_o,
	output logic [15:0] sleep_wake_delay_o,
	output logic [15:0] sleep_wake_whole_o,
	output logic [3:0] sleep_wake_tenth_o
);
	import mer_pkg::*;

	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	mer_state_type state_r;
	logic req_ready_r;
	logic unlocked_r;
	logic [15:0] run_src_r;
	logic [15:0] sleep_r;
	wire accept = req_valid_i && req_ready_r;
	wire is_read = (req_func_i == `MER_FC_READ);
	wire is_write = (req_func_i == `MER_FC_WRITE);
	wire at_run = (req_reg_i == `MER_RUN_CMD_SRC_OFS);
	wire at_sleep = (req_reg_i == `MER_SLEEP_WAKE_OFS);
	wire at_pwd = (req_reg_i == `MER_PWD_VERIFY_OFS);
	wire at_id = (req_reg_i == `MER_DEVICE_ID_OFS);
	wire readable = at_run || at_sleep || at_id;
	wire mapped = readable || at_pwd;
	wire locked = (user_password_setting_i != 16'h0000) && !unlocked_r;
	wire pwd_try = is_write && at_pwd;
	wire out_range = (at_run && (req_data_i > `MER_RUN_CMD_SRC_MAX))
		|| (at_sleep && (req_data_i > `MER_SLEEP_WAKE_MAX));
	wire [15:0] read_val = at_run ? run_src_r : (at_sleep ? sleep_r : `MER_DEVICE_ID_VAL);

	// ---------------------------------------------------------------
	// error priority: frame first, then command, lock, address, value
	// ---------------------------------------------------------------
	wire [7:0] err_code =
		(!req_len_ok_i || !req_crc_ok_i) ? `MER_ERR_FRAME :
		(!is_read && !is_write) ? `MER_ERR_COMMAND :
		drive_fault_i ? `MER_ERR_COMMAND :
		(locked && !pwd_try) ? `MER_ERR_LOCKED :
		(is_read && !readable) ? `MER_ERR_ADDRESS :
		(is_write && !mapped) ? `MER_ERR_ADDRESS :
		(is_read && (req_data_i == 16'h0000)) ? `MER_ERR_DATA :
		(is_read && (req_data_i != 16'h0001)) ? `MER_ERR_ADDRESS :
		(is_write && at_id) ? `MER_ERR_READ_ONLY :
		(is_write && at_run && drive_running_i) ? `MER_ERR_RUNNING :
		(is_write && out_range) ? `MER_ERR_VALUE :
		(pwd_try && (req_data_i != user_password_setting_i)) ? `MER_ERR_PASSWORD :
		`MER_ERR_NONE;
	wire is_exc = (err_code != `MER_ERR_NONE);
	wire commit = accept && !is_exc && is_write;

	// ---------------------------------------------------------------
	// parameter store and password unlock
	// ---------------------------------------------------------------
	// link integer is kept as is; engineering value is integer over scale
	wire [15:0] sleep_whole_nxt = sleep_r / `MER_SLEEP_WAKE_SCALE;
	wire [15:0] sleep_rem = sleep_r % `MER_SLEEP_WAKE_SCALE;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			run_src_r <= `MER_RUN_CMD_SRC_RST;
			sleep_r <= `MER_SLEEP_WAKE_RST;
			unlocked_r <= 1'b0;
			sleep_wake_whole_o <= 16'h0000;
			sleep_wake_tenth_o <= 4'h0;
		end else begin
			if (commit && at_run)
				run_src_r <= req_data_i;
			if (commit && at_sleep)
				sleep_r <= req_data_i;
			if (commit && at_pwd)
				unlocked_r <= 1'b1;
			sleep_wake_whole_o <= sleep_whole_nxt;
			sleep_wake_tenth_o <= sleep_rem[3:0];
		end
	end
	assign run_command_source_o = run_src_r;
	assign sleep_wake_delay_o = sleep_r;
	assign unlocked_o = unlocked_r;

	// ---------------------------------------------------------------
	// response body assembly
	// ---------------------------------------------------------------
	mer_byte_type body_r [0:5];
	logic [2:0] body_len_r;
	logic [2:0] idx_r;
	logic [15:0] crc_r;
	logic exc_r;
	wire [7:0] fc_out = is_exc ? (req_func_i | `MER_FC_EXC_BIT) : req_func_i;
	wire [7:0] b2 = is_exc ? err_code : (is_read ? `MER_BYTE_COUNT_ONE : req_reg_i[15:8]);
	wire [7:0] b3 = is_read ? read_val[15:8] : req_reg_i[7:0];
	wire [7:0] b4 = is_read ? read_val[7:0] : req_data_i[15:8];
	wire [2:0] len_nxt = is_exc ? 3'd3 : (is_read ? 3'd5 : 3'd6);
	always_ff @(posedge clk_sys_i) begin
		if (accept) begin
			body_r[0] <= req_slave_i;
			body_r[1] <= fc_out;
			body_r[2] <= b2;
			body_r[3] <= b3;
			body_r[4] <= b4;
			body_r[5] <= req_data_i[7:0];
			body_len_r <= len_nxt;
		end
	end

	// crc-16 step over one byte, reflected polynomial
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ `MER_CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_step

	// ---------------------------------------------------------------
	// framer state machine
	// ---------------------------------------------------------------
	wire body_done = (idx_r == body_len_r - 3'd1);
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_r <= MER_IDLE;
			req_ready_r <= 1'b1;
			idx_r <= 3'd0;
			crc_r <= `MER_CRC_INIT;
			exc_r <= 1'b0;
			tx_byte_o <= 8'h00;
			tx_valid_o <= 1'b0;
			tx_last_o <= 1'b0;
			tx_exception_o <= 1'b0;
		end else begin
			tx_valid_o <= 1'b0;
			tx_last_o <= 1'b0;
			case (state_r)
				MER_IDLE: begin
					idx_r <= 3'd0;
					crc_r <= `MER_CRC_INIT;
					tx_exception_o <= 1'b0;                               // flag only spans a frame
					if (accept) begin
						req_ready_r <= 1'b0;
						exc_r <= is_exc;
						state_r <= MER_BODY;
					end
				end
				MER_BODY: begin
					tx_byte_o <= body_r[idx_r];
					tx_valid_o <= 1'b1;
					tx_exception_o <= exc_r;
					crc_r <= crc_step(crc_r, body_r[idx_r]);
					idx_r <= idx_r + 3'd1;
					if (body_done)
						state_r <= MER_CRC_LO;
				end
				MER_CRC_LO: begin
					tx_byte_o <= crc_r[7:0];
					tx_valid_o <= 1'b1;
					state_r <= MER_CRC_HI;
				end
				MER_CRC_HI: begin
					tx_byte_o <= crc_r[15:8];
					tx_valid_o <= 1'b1;
					tx_last_o <= 1'b1;
					req_ready_r <= 1'b1;
					state_r <= MER_IDLE;
				end
				default: begin
					state_r <= MER_IDLE;
				end
			endcase
		end
	end
	assign req_ready_o = req_ready_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	// expected exception crc, built from the request slave, function code and err_code
	wire [15:0] exc_crc_exp = crc_step(crc_step(crc_step(`MER_CRC_INIT, req_slave_i),
		req_func_i | `MER_FC_EXC_BIT), err_code);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	a_norm_fcode_echo: assert property (accept && !is_exc |->
		##3 tx_byte_o == $past(req_func_i, 3))
		else $error("normal response altered function code");
	a_exc_fcode_msb: assert property (accept && is_exc |->
		##3 tx_byte_o == ($past(req_func_i, 3) | 8'h80))
		else $error("exception function code top bit not set");
	a_exc_frame_order: assert property (accept && is_exc |->
		##2 tx_byte_o == $past(req_slave_i, 2) ##2 tx_byte_o == $past(err_code, 4)
		##2 tx_last_o)
		else $error("exception frame layout wrong");
	a_exc_crc_calc: assert property (accept && is_exc |->
		##5 tx_byte_o == $past(exc_crc_exp[7:0], 5)
		##1 tx_byte_o == $past(exc_crc_exp[15:8], 6))
		else $error("exception crc bytes wrong");
	a_sleep_scaled_store: assert property (commit && at_sleep |->
		##2 sleep_wake_whole_o == $past(req_data_i, 2) / 16'd10
		&& sleep_wake_tenth_o == 4'($past(req_data_i, 2) % 16'd10))
		else $error("scaled value not stored");
	a_frame_err_code: assert property (accept && !req_crc_ok_i |->
		##4 tx_byte_o == 8'h06)
		else $error("bad crc not reported as 06");
	a_fault_err_code: assert property (accept && req_len_ok_i && req_crc_ok_i
		&& drive_fault_i |-> err_code == 8'h01)
		else $error("fault not reported as 01");
	a_lock_err_code: assert property (accept && req_len_ok_i && req_crc_ok_i
		&& is_read && !drive_fault_i && locked |-> err_code == 8'h09)
		else $error("locked read not reported as 09");
	a_ro_err_code: assert property (accept && req_len_ok_i && req_crc_ok_i
		&& is_write && at_id && !drive_fault_i && !locked |-> err_code == 8'h07)
		else $error("read-only write not reported as 07");
	a_run_err_code: assert property (accept && req_len_ok_i && req_crc_ok_i
		&& is_write && at_run && drive_running_i && !drive_fault_i && !locked
		|-> err_code == 8'h08 ##1 $stable(run_src_r) [*2])
		else $error("write while running not refused with 08");
	a_pwd_err_code: assert property (pwd_try && accept && err_code == 8'h05
		|=> !unlocked_r || $past(unlocked_r))
		else $error("wrong password unlocked the port");
	c_exception: cover property (accept && is_exc ##6 tx_last_o);
	c_write_ok: cover property (commit && at_sleep);
	c_read_ok: cover property (accept && is_read && !is_exc);
	c_unlock: cover property (commit && at_pwd);
endmodule : mer_responder
`default_nettype wire

// file: logic/mer_regs.svh
// register offsets, codes and reset values of the exception responder
`ifndef MER_REGS_SVH
`define MER_REGS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define MER_RUN_CMD_SRC_OFS 16'h0001
`define MER_SLEEP_WAKE_OFS 16'h0114
`define MER_PWD_VERIFY_OFS 16'h0700
`define MER_DEVICE_ID_OFS 16'h2103
// ---------------------------------------------------------------
// reset values, ranges and fieldbus scales
// ---------------------------------------------------------------
`define MER_RUN_CMD_SRC_RST 16'h0000
`define MER_SLEEP_WAKE_RST 16'h0000
`define MER_RUN_CMD_SRC_MAX 16'h0002
`define MER_SLEEP_WAKE_MAX 16'h8ca0
`define MER_SLEEP_WAKE_SCALE 16'h000a
`define MER_DEVICE_ID_VAL 16'h5a5a
// ---------------------------------------------------------------
// function codes and error codes
// ---------------------------------------------------------------
`define MER_FC_READ 8'h03
`define MER_FC_WRITE 8'h06
`define MER_FC_EXC_BIT 8'h80
`define MER_BYTE_COUNT_ONE 8'h02
`define MER_ERR_NONE 8'h00
`define MER_ERR_COMMAND 8'h01
`define MER_ERR_ADDRESS 8'h02
`define MER_ERR_DATA 8'h03
`define MER_ERR_VALUE 8'h04
`define MER_ERR_PASSWORD 8'h05
`define MER_ERR_FRAME 8'h06
`define MER_ERR_READ_ONLY 8'h07
`define MER_ERR_RUNNING 8'h08
`define MER_ERR_LOCKED 8'h09
// ---------------------------------------------------------------
// crc
// ---------------------------------------------------------------
`define MER_CRC_INIT 16'hffff
`define MER_CRC_POLY 16'ha001
`endif

// file: logic/mer_pkg.sv
// types shared by the exception responder
`default_nettype none
package mer_pkg;
	typedef enum logic [1:0] {
		MER_IDLE = 2'b00,
		MER_BODY = 2'b01,
		MER_CRC_LO = 2'b10,
		MER_CRC_HI = 2'b11
	} mer_state_type;
	typedef logic [7:0] mer_byte_type;
endpackage : mer_pkg
`default_nettype wire

// file: verification/mer_master_model.sv
// master-side model that collects and crc-checks response frames
`timescale 1ns/1ps
`default_nettype none
module mer_master_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_valid_i,
	input wire logic tx_last_i,
	input wire logic tx_exception_i,
	output logic [79:0] frame_o,
	output logic [3:0] len_o,
	output logic [15:0] crc_o,
	output logic exc_o,
	output logic [7:0] frames_o
);
	logic open_r = 1'b0;
	initial begin
		frames_o = 8'h00;
	end
	// one byte of the reflected crc-16
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
		end
		return r;
	endfunction : crc_step
	// gather bytes; crc over a frame including its own crc ends at zero
	always @(posedge clk_sys_i) begin
		if (tx_valid_i) begin
			frame_o <= open_r ? {frame_o[71:0], tx_byte_i} : {72'h0, tx_byte_i};
			len_o <= open_r ? len_o + 4'h1 : 4'h1;
			crc_o <= crc_step(open_r ? crc_o : 16'hffff, tx_byte_i);
			if (!open_r) exc_o <= tx_exception_i;
			open_r <= !tx_last_i;
			if (tx_last_i) frames_o <= frames_o + 8'h01;
		end
	end
endmodule : mer_master_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench of the exception responder
`timescale 1ns/1ps
`default_nettype none
`include "mer_regs.svh"
module testbench;
	import mer_pkg::*;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_valid_i = 1'b0;
	mer_byte_type req_func_i = 8'h00;
	logic [15:0] req_reg_i = 16'h0000;
	logic [15:0] req_data_i = 16'h0000;
	logic [3:0] flags = 4'b1100;
	logic [15:0] user_password_setting_i = 16'h0000;
	logic req_ready_o, tx_valid_o, tx_last_o, tx_exception_o, unlocked_o, exc;
	mer_byte_type tx_byte_o;
	logic [15:0] run_command_source_o, sleep_wake_delay_o, sleep_wake_whole_o, crc;
	logic [3:0] sleep_wake_tenth_o, len;
	logic [79:0] frame;
	logic [7:0] frames;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	mer_responder mer_responder_inst (.clk_sys_i, .srst_i, .req_valid_i, .req_slave_i(8'h01),
		.req_func_i, .req_reg_i, .req_data_i, .req_len_ok_i(flags[3]), .req_crc_ok_i(flags[2]),
		.drive_fault_i(flags[1]), .drive_running_i(flags[0]), .user_password_setting_i,
		.req_ready_o, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_exception_o, .unlocked_o,
		.run_command_source_o, .sleep_wake_delay_o, .sleep_wake_whole_o, .sleep_wake_tenth_o);
	mer_master_model mer_master_model_inst (.clk_sys_i, .tx_byte_i(tx_byte_o),
		.tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_exception_i(tx_exception_o),
		.frame_o(frame), .len_o(len), .crc_o(crc), .exc_o(exc), .frames_o(frames));
	task automatic complete_run();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [79:0] got, input logic [79:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// master scales a value with one decimal place by ten
	function automatic logic [15:0] to_link(input logic [15:0] w, input logic [3:0] t);
		return w * 16'd10 + {12'h0, t};
	endfunction : to_link
	// one request, then wait a bounded time for the whole response
	task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] fl = 4'b1100);
		logic [7:0] seen;
		seen = frames;
		flags <= fl;
		req_valid_i <= 1'b1;
		req_func_i <= f;
		req_reg_i <= a;
		req_data_i <= d;
		do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
		req_valid_i <= 1'b0;
		for (int i = 0; i < 20 && frames == seen; i++) @(posedge clk_sys_i);
		check(80'(frames), 80'(seen + 8'h01), "frame count");
		check({64'h0, crc}, 80'h0, "frame crc");
	endtask : send
	task automatic exc_case(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] fl, input logic [7:0] err);
		send(f, a, d, fl);
		check({56'h0, frame[39:16]}, {56'h0, 8'h01, f | 8'h80, err}, "exception head");
		check({75'h0, exc, len}, 80'h15, "exception flag and length");
	endtask : exc_case
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		check({47'h0, unlocked_o, run_command_source_o, sleep_wake_delay_o}, 80'h0, "reset");
		send(8'h06, `MER_SLEEP_WAKE_OFS, to_link(16'd5, 4'd0));
		check(frame, 80'h0106_0114_0032_49e7, "write echo");
		check({75'h0, exc, len}, 80'h08, "write flag and length");
		check({60'h0, sleep_wake_whole_o, sleep_wake_tenth_o}, 80'h00050, "5.0 s");
		check({64'h0, sleep_wake_delay_o}, 80'h32, "link integer kept");
		send(8'h06, `MER_SLEEP_WAKE_OFS, to_link(16'd12, 4'd3));
		check({60'h0, sleep_wake_whole_o, sleep_wake_tenth_o}, 80'h000c3, "12.3 s");
		send(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001);
		check({40'h0, frame[55:16]}, 80'h01_03_02_00_7b, "read data");
		exc_case(8'h06, `MER_RUN_CMD_SRC_OFS, 16'h0003, 4'b1100, 8'h04);
		check(frame, 80'h01_86_04_43a3, "range exception");
		send(8'h06, `MER_RUN_CMD_SRC_OFS, 16'h0002);
		check({64'h0, run_command_source_o}, 80'h2, "corrected write");
		send(8'h03, `MER_RUN_CMD_SRC_OFS, 16'h0001);
		check({40'h0, frame[55:16]}, 80'h01_03_02_00_02, "run source read");
		send(8'h03, `MER_DEVICE_ID_OFS, 16'h0001);
		check({40'h0, frame[55:16]}, {40'h0, 24'h01_03_02, `MER_DEVICE_ID_VAL}, "id read");
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001, 4'b0100, 8'h06);
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001, 4'b1000, 8'h06);
		exc_case(8'h10, `MER_SLEEP_WAKE_OFS, 16'h0001, 4'b1100, 8'h01);
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001, 4'b1110, 8'h01);
		exc_case(8'h03, 16'h0500, 16'h0001, 4'b1100, 8'h02);
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0002, 4'b1100, 8'h02);
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0000, 4'b1100, 8'h03);
		exc_case(8'h06, `MER_SLEEP_WAKE_OFS, 16'h8ca1, 4'b1100, 8'h04);
		exc_case(8'h06, `MER_DEVICE_ID_OFS, 16'h0001, 4'b1100, 8'h07);
		exc_case(8'h06, `MER_RUN_CMD_SRC_OFS, 16'h0001, 4'b1101, 8'h08);
		user_password_setting_i <= 16'h1234;
		exc_case(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001, 4'b1100, 8'h09);
		exc_case(8'h06, `MER_PWD_VERIFY_OFS, 16'h1111, 4'b1100, 8'h05);
		send(8'h06, `MER_PWD_VERIFY_OFS, 16'h1234);
		check(80'(unlocked_o), 80'h1, "unlocked");
		send(8'h03, `MER_SLEEP_WAKE_OFS, 16'h0001);
		check({76'h0, exc, len[2:0]}, 80'h7, "read after unlock");
		complete_run();
	end
endmodule : testbench
`default_nettype wire
